// ==== rtl/ats_seq.sv ====
// converter trigger sequencer with its wishbone register file
// ------------------------------------------------------------
// Summary of operation
// - pwm mode starts on period or duty event
// - optional delay of count system clocks
// - busy flag clears when conversion ends
// - done flag set at end, interrupt if enabled
// - divider codes give fsys over powers of two
// - power-off bit shuts the converter down
// - compare result to bounds, interrupt on reaching or passing one
// - analog select disables pin digital functions
// - analog select disconnects the pin pull-up
// - analog select overrides port direction
// - start bit rise then fall starts conversion
// - trigger source bit picks software or pwm
// - done interrupt needs global and local enable
// - conversion lasts sixteen converter clocks
// - ten-bit result split over two registers
// - start bit held high resets, busy high
// - four-bit channel select, code 1000 current
// ------------------------------------------------------------
module ats_seq
(
   input  wire logic        clock,
   input  wire logic        rst,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic [31:0]      wb_dat_o,
   output logic             wb_ack_o,
   input  wire logic        pwm_period_evt,
   input  wire logic        pwm_duty_evt,
   input  wire logic [9:0]  ana_result,
   output logic             ana_power_off,
   output logic             ana_reset,
   output logic             ana_clk_en,
   output logic             ana_convert,
   output logic [3:0]       ana_channel,
   input  wire logic [8:0]  port_dir_in,
   input  wire logic [8:0]  pullup_req,
   output logic [8:0]       pin_analog,
   output logic [8:0]       pin_digital_en,
   output logic [8:0]       pin_dir_input,
   output logic [8:0]       pin_pullup_en,
   output logic             conv_done_irq,
   output logic             bound_irq
);

   // ------------------------------------------------------------
   // state and registers
   // ------------------------------------------------------------
   typedef enum logic [1:0] {ST_IDLE, ST_DELAY, ST_CONV} ats_state_t;

   ats_state_t          state_q;
   ats_state_t          state_d;
   ats_pkg::ats_ctrl0_t ctrl0_q;
   ats_pkg::ats_ctrl1_t ctrl1_q;
   logic [8:0]          pins_q;
   logic [7:0]          delay_q;
   logic [9:0]          low_q;
   logic [9:0]          high_q;
   logic [9:0]          res_q;
   logic                glob_en_q;
   logic                done_en_q;
   logic                done_flg_q;
   logic                bound_flg_q;
   logic                start_prev_q;
   logic [7:0]          dly_cnt_q;
   logic [7:0]          dly_cnt_d;
   logic [4:0]          tick_cnt_q;
   logic [4:0]          tick_cnt_d;
   logic                busy_d;

   // ------------------------------------------------------------
   // wishbone decode
   // ------------------------------------------------------------
   wire        req      = wb_cyc_i && wb_stb_i;
   wire        wr_lane  = req && wb_we_i && wb_ack_o && wb_sel_i[0];
   wire [7:0]  wd       = wb_dat_i[7:0];
   wire        wr_ctrl0 = wr_lane && (wb_adr_i == ats_pkg::OFS_CTRL0);
   wire        wr_ctrl1 = wr_lane && (wb_adr_i == ats_pkg::OFS_CTRL1);
   wire        wr_pl    = wr_lane && (wb_adr_i == ats_pkg::OFS_PINS_LO);
   wire        wr_ph    = wr_lane && (wb_adr_i == ats_pkg::OFS_PINS_HI);
   wire        wr_dly   = wr_lane && (wb_adr_i == ats_pkg::OFS_DELAY);
   wire        wr_ll    = wr_lane && (wb_adr_i == ats_pkg::OFS_LOW_LO);
   wire        wr_lh    = wr_lane && (wb_adr_i == ats_pkg::OFS_LOW_HI);
   wire        wr_hl    = wr_lane && (wb_adr_i == ats_pkg::OFS_HIGH_LO);
   wire        wr_hh    = wr_lane && (wb_adr_i == ats_pkg::OFS_HIGH_HI);
   wire        wr_irq   = wr_lane && (wb_adr_i == ats_pkg::OFS_IRQ);
   wire [7:0]  irq_rd   = {4'h0, bound_flg_q, done_flg_q,
                           done_en_q, glob_en_q};
   wire [7:0]  rd_byte  =
      (wb_adr_i == ats_pkg::OFS_RES_LO)  ? res_q[7:0] :
      (wb_adr_i == ats_pkg::OFS_RES_HI)  ? {6'h00, res_q[9:8]} :
      (wb_adr_i == ats_pkg::OFS_CTRL0)   ? 8'(ctrl0_q & 8'hef) :
      (wb_adr_i == ats_pkg::OFS_CTRL1)   ? 8'(ctrl1_q) :
      (wb_adr_i == ats_pkg::OFS_PINS_LO) ? pins_q[7:0] :
      (wb_adr_i == ats_pkg::OFS_PINS_HI) ? {7'h00, pins_q[8]} :
      (wb_adr_i == ats_pkg::OFS_DELAY)   ? delay_q :
      (wb_adr_i == ats_pkg::OFS_LOW_LO)  ? low_q[7:0] :
      (wb_adr_i == ats_pkg::OFS_LOW_HI)  ? {6'h00, low_q[9:8]} :
      (wb_adr_i == ats_pkg::OFS_HIGH_LO) ? high_q[7:0] :
      (wb_adr_i == ats_pkg::OFS_HIGH_HI) ? {6'h00, high_q[9:8]} :
      (wb_adr_i == ats_pkg::OFS_IRQ)     ? irq_rd : 8'h00;

   // ------------------------------------------------------------
   // trigger selection
   // ------------------------------------------------------------
   wire powered   = !ctrl0_q.converter_power_off;
   wire start_hi  = ctrl0_q.start_conv_bit;
   // release of the start bit, seen one cycle after the write lands
   wire sw_fall   = start_prev_q && !start_hi;
   wire sw_trig   = !ctrl1_q.trigger_source_select && sw_fall;
   wire pwm_evt   = ctrl1_q.pwm_event_select ? pwm_duty_evt
                                             : pwm_period_evt;
   wire pwm_trig  = ctrl1_q.trigger_source_select && pwm_evt;
   // a zero count with delay on starts at once rather than hanging
   wire dly_go    = ctrl1_q.delay_start_enable && (delay_q != 8'h00);
   wire conv_go   = powered && !start_hi &&
                    (sw_trig || (pwm_trig && !dly_go) ||
                     (state_q == ST_DELAY && dly_cnt_q == 8'h01));
   wire hold_rst  = start_hi || !powered;

   // ------------------------------------------------------------
   // converter clock and end of conversion
   // ------------------------------------------------------------
   logic tick;
   logic bnd_hit;

   ats_clk_div u_div
   (
      .clock   (clock),
      .rst     (rst),
      .restart (conv_go),
      .div_sel (ctrl1_q.clock_divider_select),
      .tick    (tick)
   );

   wire conv_end = (state_q == ST_CONV) && tick &&
                   (tick_cnt_q == 5'(ats_pkg::CONV_CLKS - 5'h01)) &&
                   !hold_rst;

   wire ats_pkg::ats_bound_t bnd =
      '{low_boundary_value:  low_q,
        high_boundary_value: high_q,
        mode: {ctrl1_q.high_bound_compare_enable,
               ctrl1_q.low_bound_compare_enable}};

   ats_bound_cmp u_cmp
   (
      .bnd    (bnd),
      .result (ana_result),
      .hit    (bnd_hit)
   );

   // ------------------------------------------------------------
   // sequencer
   // ------------------------------------------------------------
   always_comb
   begin
      state_d    = state_q;
      dly_cnt_d  = dly_cnt_q;
      tick_cnt_d = tick_cnt_q;
      busy_d     = ctrl0_q.conv_busy_flag;
      case (state_q)
         ST_IDLE:
         begin
            if (conv_go)
            begin
               state_d    = ST_CONV;
               tick_cnt_d = 5'h00;
               busy_d     = 1'b1;
            end
            else if (powered && !start_hi && pwm_trig && dly_go)
            begin
               state_d   = ST_DELAY;
               dly_cnt_d = delay_q;
            end
         end
         ST_DELAY:
         begin
            if (conv_go)
            begin
               state_d    = ST_CONV;
               tick_cnt_d = 5'h00;
               busy_d     = 1'b1;
            end
            else
            begin
               dly_cnt_d = 8'(dly_cnt_q - 8'h01);
            end
         end
         ST_CONV:
         begin
            if (tick)
            begin
               tick_cnt_d = 5'(tick_cnt_q + 5'h01);
            end
            if (conv_end)
            begin
               state_d = ST_IDLE;
               busy_d  = 1'b0;
            end
         end
         default:
         begin
            state_d = ST_IDLE;
         end
      endcase
      // held start bit or power-off aborts whatever is running
      if (hold_rst)
      begin
         state_d = ST_IDLE;
         if (start_hi)
         begin
            busy_d = 1'b1;
         end
      end
   end

   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         state_q      <= ST_IDLE;
         dly_cnt_q    <= 8'h00;
         tick_cnt_q   <= 5'h00;
         start_prev_q <= 1'b0;
      end
      else
      begin
         state_q      <= state_d;
         dly_cnt_q    <= dly_cnt_d;
         tick_cnt_q   <= tick_cnt_d;
         start_prev_q <= start_hi;
      end
   end

   // ------------------------------------------------------------
   // control registers
   // ------------------------------------------------------------
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         ctrl0_q <= ats_pkg::ats_ctrl0_t'(ats_pkg::CTRL0_RST);
         ctrl1_q <= ats_pkg::ats_ctrl1_t'(ats_pkg::CTRL1_RST);
      end
      else
      begin
         if (wr_ctrl0)
         begin
            ctrl0_q.start_conv_bit      <= wd[7];
            ctrl0_q.converter_power_off <= wd[5];
            ctrl0_q.channel_select      <= wd[3:0];
         end
         ctrl0_q.conv_busy_flag <= busy_d;
         ctrl0_q.unused         <= 1'b0;
         if (wr_ctrl1)
         begin
            ctrl1_q <= ats_pkg::ats_ctrl1_t'(wd);
         end
      end
   end

   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         pins_q  <= ats_pkg::PINS_RST;
         delay_q <= 8'h00;
         low_q   <= 10'h000;
         high_q  <= 10'h000;
      end
      else
      begin
         if (wr_pl)
            pins_q[7:0] <= wd;
         if (wr_ph)
            pins_q[8] <= wd[0];
         if (wr_dly)
            delay_q <= wd;
         if (wr_ll)
            low_q[7:0] <= wd;
         if (wr_lh)
            low_q[9:8] <= wd[1:0];
         if (wr_hl)
            high_q[7:0] <= wd;
         if (wr_hh)
            high_q[9:8] <= wd[1:0];
      end
   end

   // ------------------------------------------------------------
   // result and interrupt flags
   // ------------------------------------------------------------
   // result keeps its old value until busy falls, so a poller that
   // waits for busy low always reads a whole, consistent pair
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         res_q       <= 10'h000;
         glob_en_q   <= 1'b0;
         done_en_q   <= 1'b0;
         done_flg_q  <= 1'b0;
         bound_flg_q <= 1'b0;
      end
      else
      begin
         if (conv_end)
            res_q <= ana_result;
         if (wr_irq)
         begin
            glob_en_q <= wd[ats_pkg::IRQ_GLOBAL_EN];
            done_en_q <= wd[ats_pkg::IRQ_DONE_EN];
         end
         // set wins over a software clear in the same cycle
         done_flg_q  <= conv_end ||
                        (done_flg_q &&
                         !(wr_irq && !wd[ats_pkg::IRQ_DONE_FLAG]));
         bound_flg_q <= (conv_end && bnd_hit) ||
                        (bound_flg_q &&
                         !(wr_irq && !wd[ats_pkg::IRQ_BOUND_FLG]));
      end
   end

   // ------------------------------------------------------------
   // registered outputs
   // ------------------------------------------------------------
   logic [8:0] pin_an_d;
   logic [8:0] pin_dig_d;
   logic [8:0] pin_dir_d;
   logic [8:0] pin_pu_d;

   for (genvar i = 0; i < ats_pkg::PIN_N; i++)
   begin : g_pin
      assign pin_an_d[i]  = pins_q[i];
      assign pin_dig_d[i] = !pins_q[i];
      assign pin_dir_d[i] = pins_q[i] || port_dir_in[i];
      assign pin_pu_d[i]  = !pins_q[i] && pullup_req[i];
   end

   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         wb_ack_o       <= 1'b0;
         wb_dat_o       <= 32'h0000_0000;
         ana_power_off  <= 1'b1;
         ana_reset      <= 1'b1;
         ana_clk_en     <= 1'b0;
         ana_convert    <= 1'b0;
         ana_channel    <= 4'h0;
         pin_analog     <= ats_pkg::PINS_RST;
         pin_digital_en <= 9'h000;
         pin_dir_input  <= ats_pkg::PINS_RST;
         pin_pullup_en  <= 9'h000;
         conv_done_irq  <= 1'b0;
         bound_irq      <= 1'b0;
      end
      else
      begin
         wb_ack_o       <= req && !wb_ack_o;
         wb_dat_o       <= (req && !wb_ack_o) ? {24'h00_0000, rd_byte}
                                              : wb_dat_o;
         ana_power_off  <= ctrl0_q.converter_power_off;
         ana_reset      <= hold_rst;
         ana_clk_en     <= tick && (state_q == ST_CONV);
         // trails the state by one cycle, in step with ana_clk_en, so
         // the last converter clock pulse still falls inside the window
         ana_convert    <= state_q == ST_CONV;
         ana_channel    <= ctrl0_q.channel_select;
         pin_analog     <= pin_an_d;
         pin_digital_en <= pin_dig_d;
         pin_dir_input  <= pin_dir_d;
         pin_pullup_en  <= pin_pu_d;
         conv_done_irq  <= done_flg_q && done_en_q && glob_en_q;
         bound_irq      <= bound_flg_q && glob_en_q;
      end
   end

endmodule

// ==== rtl/ats_pkg.sv ====
// package: register map, field layout and timing for the trigger sequencer
package ats_pkg;

   // ------------------------------------------------------------
   // register byte addresses
   // ------------------------------------------------------------
   localparam logic [7:0] OFS_RES_LO  = 8'h00;
   localparam logic [7:0] OFS_RES_HI  = 8'h04;
   localparam logic [7:0] OFS_CTRL0   = 8'h08;
   localparam logic [7:0] OFS_CTRL1   = 8'h0c;
   localparam logic [7:0] OFS_PINS_LO = 8'h10;
   localparam logic [7:0] OFS_PINS_HI = 8'h14;
   localparam logic [7:0] OFS_DELAY   = 8'h18;
   localparam logic [7:0] OFS_LOW_LO  = 8'h1c;
   localparam logic [7:0] OFS_LOW_HI  = 8'h20;
   localparam logic [7:0] OFS_HIGH_LO = 8'h24;
   localparam logic [7:0] OFS_HIGH_HI = 8'h28;
   localparam logic [7:0] OFS_IRQ     = 8'h2c;

   // ------------------------------------------------------------
   // interrupt control register bit positions
   // ------------------------------------------------------------
   localparam int IRQ_GLOBAL_EN = 0;
   localparam int IRQ_DONE_EN   = 1;
   localparam int IRQ_DONE_FLAG = 2;
   localparam int IRQ_BOUND_FLG = 3;

   // ------------------------------------------------------------
   // widths, reset values and timing
   // ------------------------------------------------------------
   localparam int         RES_W       = 10;
   localparam int         PIN_N       = 9;
   localparam logic [7:0] CTRL0_RST   = 8'h60;
   localparam logic [7:0] CTRL1_RST   = 8'h00;
   localparam logic [8:0] PINS_RST    = 9'h1ff;
   localparam logic [4:0] CONV_CLKS   = 5'h10;
   localparam logic [2:0] DIV_UNDEF   = 3'h7;
   localparam logic [2:0] DIV_MAX     = 3'h6;
   localparam logic [1:0] CMP_LOW     = 2'h1;
   localparam logic [1:0] CMP_HIGH    = 2'h2;
   localparam logic [1:0] CMP_BOTH    = 2'h3;

   // ------------------------------------------------------------
   // carriers
   // ------------------------------------------------------------
   typedef struct packed {
      logic       start_conv_bit;
      logic       conv_busy_flag;
      logic       converter_power_off;
      logic       unused;
      logic [3:0] channel_select;
   } ats_ctrl0_t;

   typedef struct packed {
      logic       trigger_source_select;
      logic       delay_start_enable;
      logic       pwm_event_select;
      logic       high_bound_compare_enable;
      logic       low_bound_compare_enable;
      logic [2:0] clock_divider_select;
   } ats_ctrl1_t;

   typedef struct packed {
      logic [9:0] low_boundary_value;
      logic [9:0] high_boundary_value;
      logic [1:0] mode;
   } ats_bound_t;

endpackage

// ==== rtl/ats_clk_div.sv ====
// converter clock enable divider, power-of-two ratios
module ats_clk_div
(
   input  wire logic       clock,
   input  wire logic       rst,
   input  wire logic       restart,
   input  wire logic [2:0] div_sel,
   output logic            tick
);

   logic [5:0] cnt_q;
   logic [5:0] mask;
   logic [2:0] sel_eff;
   logic       wrap;

   // undefined code is held at the slowest ratio so it stays safe
   assign sel_eff = (div_sel == ats_pkg::DIV_UNDEF) ? ats_pkg::DIV_MAX
                                                     : div_sel;
   assign mask    = 6'(7'h7f >> (3'h7 - sel_eff)) & 6'h3f;
   assign wrap    = (cnt_q & mask) == mask;

   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         cnt_q <= 6'h00;
         tick  <= 1'b0;
      end
      else
      begin
         cnt_q <= restart ? 6'h00 : 6'(cnt_q + 6'h01);
         tick  <= !restart && wrap;
      end
   end

endmodule

// ==== rtl/ats_bound_cmp.sv ====
// boundary comparison of a fresh result against the two limits
module ats_bound_cmp
(
   input  wire ats_pkg::ats_bound_t bnd,
   input  wire logic [9:0]          result,
   output logic                     hit
);

   logic below;
   logic above;

   assign below = result <= bnd.low_boundary_value;
   assign above = result >= bnd.high_boundary_value;
   assign hit   = (bnd.mode == ats_pkg::CMP_LOW)  ? below :
                  (bnd.mode == ats_pkg::CMP_HIGH) ? above :
                  (bnd.mode == ats_pkg::CMP_BOTH) ? (below || above) :
                  1'b0;

endmodule

// ==== testbench/ats_seq_assertions.sv ====
// checker: port-level properties of the trigger sequencer
module ats_seq_assertions
(
   input wire logic       clock,
   input wire logic       rst,
   input wire logic       wb_cyc_i,
   input wire logic       wb_stb_i,
   input wire logic       wb_ack_o,
   input wire logic       ana_power_off,
   input wire logic       ana_reset,
   input wire logic       ana_clk_en,
   input wire logic       ana_convert,
   input wire logic [8:0] pin_analog,
   input wire logic [8:0] pin_digital_en,
   input wire logic [8:0] pin_dir_input,
   input wire logic [8:0] pin_pullup_en
);
   // pulses seen during the current conversion
   logic [4:0] pls_q;
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
         pls_q <= 5'h00;
      else if (!ana_convert)
         pls_q <= 5'h00;
      else if (ana_clk_en)
         pls_q <= pls_q + 5'h01;
   end
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   sequence s_req;
      wb_cyc_i && wb_stb_i && !wb_ack_o;
   endsequence
   sequence s_done;
      $fell(ana_convert) && !ana_reset && !ana_power_off;
   endsequence
   // pin outputs may trail a select change by one cycle
   property p_dig;
      ((pin_digital_en ^ ~pin_analog) & ~(pin_analog ^ $past(pin_analog)))
         == 9'h000;
   endproperty
   property p_pull;
      (pin_pullup_en & pin_analog & $past(pin_analog)) == 9'h000;
   endproperty
   property p_dir;
      (pin_analog & $past(pin_analog) & ~pin_dir_input) == 9'h000;
   endproperty
   property p_ack;
      s_req |=> wb_ack_o;
   endproperty
   property p_ack_drop;
      wb_ack_o |=> !wb_ack_o;
   endproperty
   property p_len;
      s_done |-> pls_q == 5'h10;
   endproperty
   property p_clk;
      ana_clk_en |-> ana_convert;
   endproperty
   property p_off;
      ana_power_off [*2] |-> !ana_convert;
   endproperty
   property p_hold;
      ana_reset [*2] |-> !ana_convert && !ana_clk_en;
   endproperty
   a_dig: assert property (p_dig)
      else $error("digital enable wrong");
   a_pull: assert property (p_pull)
      else $error("pull-up on analog pin");
   a_dir: assert property (p_dir)
      else $error("analog pin not input");
   a_ack: assert property (p_ack)
      else $error("ack missing");
   a_ack_drop: assert property (p_ack_drop)
      else $error("ack too long");
   a_len: assert property (p_len)
      else $error("conversion length wrong");
   a_clk: assert property (p_clk)
      else $error("clock pulse outside conversion");
   a_off: assert property (p_off)
      else $error("converting while off");
   a_hold: assert property (p_hold)
      else $error("converting while held");
endmodule
bind ats_seq ats_seq_assertions chk_u
(
   .clock (clock), .rst (rst), .wb_cyc_i (wb_cyc_i), .wb_stb_i (wb_stb_i),
   .wb_ack_o (wb_ack_o), .ana_power_off (ana_power_off),
   .ana_reset (ana_reset), .ana_clk_en (ana_clk_en),
   .ana_convert (ana_convert), .pin_analog (pin_analog),
   .pin_digital_en (pin_digital_en), .pin_dir_input (pin_dir_input),
   .pin_pullup_en (pin_pullup_en)
);

// ==== testbench/ats_far_model.sv ====
// far side model: analog core result and pwm event source
module ats_far_model
(
   input  wire logic       clock,
   input  wire logic       ana_convert,
   input  wire logic [9:0] level,
   output logic [9:0]      ana_result,
   output logic            pwm_period_evt,
   output logic            pwm_duty_evt
);
   timeunit 1ns;
   timeprecision 1ps;
   initial
   begin
      ana_result = 10'h000;
      pwm_period_evt = 1'b0;
      pwm_duty_evt = 1'b0;
   end
   // result only valid while converting, otherwise it keeps toggling
   always @(posedge clock)
      ana_result <= ana_convert ? level : ~ana_result;
   task automatic fire(input logic duty);
      @(posedge clock);
      pwm_duty_evt <= duty;
      pwm_period_evt <= !duty;
      @(posedge clock);
      pwm_duty_evt <= 1'b0;
      pwm_period_evt <= 1'b0;
   endtask
endmodule

// ==== testbench/test_ats_seq.sv ====
// self-checking bench for the trigger sequencer
module test_ats_seq;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clock = 1'b0;
   logic        rst = 1'b1;
   logic        cyc = 1'b0;
   logic        stb = 1'b0;
   logic        we = 1'b0;
   logic [7:0]  adr = 8'h00;
   logic [31:0] wdat = 32'h0;
   logic [31:0] q, rd;
   logic [9:0]  level = 10'h000;
   logic [9:0]  res;
   logic [3:0]  chan;
   logic        ack, pev, dev, off, arst, clk_en, conv, dirq, birq;
   logic [8:0]  ana, dig, din, pen;
   logic [3:0]  sel = 4'hf;
   logic [8:0]  pdir = 9'h0a5;
   logic [8:0]  pup = 9'h155;
   int          errors = 0;
   int          checks = 0;
   always #20 clock = ~clock;
   ats_seq dut_u (.clock (clock), .rst (rst), .wb_cyc_i (cyc),
      .wb_stb_i (stb), .wb_we_i (we), .wb_adr_i (adr), .wb_sel_i (sel),
      .wb_dat_i (wdat), .wb_dat_o (q), .wb_ack_o (ack),
      .pwm_period_evt (pev), .pwm_duty_evt (dev), .ana_result (res),
      .ana_power_off (off), .ana_reset (arst), .ana_clk_en (clk_en),
      .ana_convert (conv), .ana_channel (chan), .port_dir_in (pdir),
      .pullup_req (pup), .pin_analog (ana), .pin_digital_en (dig),
      .pin_dir_input (din), .pin_pullup_en (pen),
      .conv_done_irq (dirq), .bound_irq (birq));
   ats_far_model far_u (.clock (clock), .ana_convert (conv),
      .level (level), .ana_result (res), .pwm_period_evt (pev),
      .pwm_duty_evt (dev));
   // --------------------------------------------------
   // bus and compare helpers
   // --------------------------------------------------
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp)
      begin
         errors++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic xfer(input logic w, input logic [7:0] a,
                       input logic [7:0] d);
      int n;
      n = 0;
      @(posedge clock);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= {24'h0, d};
      do
      begin
         @(posedge clock);
         n++;
      end
      while (ack !== 1'b1 && n < 20);
      if (n >= 20)
         errors++;
      rd = q;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      xfer(1'b1, a, d);
   endtask
   task automatic rchk(input logic [7:0] a, input logic [31:0] e);
      xfer(1'b0, a, 8'h00);
      check(rd, e);
   endtask
   task automatic sw_start(input logic [3:0] c);
      wr(ats_pkg::OFS_CTRL0, {4'h8, c});
      wr(ats_pkg::OFS_CTRL0, {4'h0, c});
   endtask
   task automatic watch(output int p, output int g);
      int n, f;
      p = 0;
      g = 0;
      f = 0;
      for (n = 0; n < 3000; n++)
      begin
         @(posedge clock);
         if (conv === 1'b1 && clk_en === 1'b1)
         begin
            f = (p == 0) ? n : f;
            g = n - f;
            p++;
         end
         if (p > 0 && conv !== 1'b1)
            break;
      end
   endtask
   task automatic lat(output int n);
      for (n = 0; n < 40 && conv !== 1'b1; n++)
         @(posedge clock);
   endtask
   task automatic irq_w(input logic [7:0] v, input logic e);
      wr(ats_pkg::OFS_IRQ, v);
      repeat (2) @(posedge clock);
      check(dirq, e);
   endtask
   // --------------------------------------------------
   // scenarios
   // --------------------------------------------------
   task automatic t_reset();
      rchk(ats_pkg::OFS_CTRL0, 8'h60);
      rchk(ats_pkg::OFS_PINS_LO, 8'hff);
      rchk(ats_pkg::OFS_PINS_HI, 8'h01);
      rchk(8'h30, 8'h00);
      check(off, 1'b1);
      sel <= 4'he;
      wr(ats_pkg::OFS_DELAY, 8'h55);
      sel <= 4'hf;
      rchk(ats_pkg::OFS_DELAY, 8'h00);
      wr(ats_pkg::OFS_PINS_LO, 8'h0f);
      wr(ats_pkg::OFS_PINS_HI, 8'h00);
      repeat (2) @(posedge clock);
      check(dig, 9'h1f0);
      check(din, 9'h0af);
      check(pen, 9'h150);
      check(ana, 9'h00f);
   endtask
   task automatic t_conv();
      int p, g, d;
      for (d = 0; d < 8; d++)
      begin
         level <= (d == 0) ? 10'h3ff : {d[2:0], 7'h2a};
         wr(ats_pkg::OFS_CTRL1, {5'h00, d[2:0]});
         sw_start(d[3:0] + 4'h2);
         watch(p, g);
         check(chan, 32'(d + 2));
         check(p, 16);
         check(g, 15 << ((d == 7) ? 6 : d));
         rchk(ats_pkg::OFS_CTRL0, 32'(d + 2));
         rchk(ats_pkg::OFS_RES_LO, level[7:0]);
         rchk(ats_pkg::OFS_RES_HI, level[9:8]);
         rchk(ats_pkg::OFS_IRQ, 8'h04);
         if (d == 0)
         begin
            irq_w(8'h06, 1'b0);
            irq_w(8'h07, 1'b1);
            irq_w(8'h05, 1'b0);
         end
         wr(ats_pkg::OFS_IRQ, 8'h00);
      end
      wr(ats_pkg::OFS_CTRL0, 8'h80);
      repeat (2) @(posedge clock);
      check(arst, 1'b1);
      rchk(ats_pkg::OFS_CTRL0, 8'hc0);
      wr(ats_pkg::OFS_CTRL0, 8'h00);
      watch(p, g);
      check(p, 16);
   endtask
   task automatic t_bound();
      logic [1:0] m [5] = '{2'h0, 2'h1, 2'h1, 2'h2, 2'h3};
      logic [9:0] v [5] = '{10'h050, 10'h100, 10'h101, 10'h200, 10'h150};
      logic       h [5] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
      int i, p, g;
      wr(ats_pkg::OFS_LOW_HI, 8'h01);
      wr(ats_pkg::OFS_HIGH_HI, 8'h02);
      for (i = 0; i < 5; i++)
      begin
         level <= v[i];
         wr(ats_pkg::OFS_IRQ, 8'h01);
         wr(ats_pkg::OFS_CTRL1, {3'h0, m[i], 3'h4});
         sw_start(4'h0);
         watch(p, g);
         rchk(ats_pkg::OFS_IRQ, {4'h0, h[i], 3'h5});
         check(birq, h[i]);
      end
      wr(ats_pkg::OFS_LOW_HI, 8'h02);
      rchk(ats_pkg::OFS_IRQ, 8'h05);
   endtask
   task automatic t_pwm();
      int n, l0, l1, p, g;
      wr(ats_pkg::OFS_DELAY, 8'h00);
      wr(ats_pkg::OFS_CTRL1, 8'h84);
      sw_start(4'h0);
      far_u.fire(1'b1);
      lat(n);
      check(n, 40);
      far_u.fire(1'b0);
      lat(l0);
      watch(p, g);
      check(p, 16);
      wr(ats_pkg::OFS_DELAY, 8'h07);
      wr(ats_pkg::OFS_CTRL1, 8'he4);
      far_u.fire(1'b1);
      lat(l1);
      watch(p, g);
      check(l1, l0 + 7);
      wr(ats_pkg::OFS_CTRL1, 8'h00);
      wr(ats_pkg::OFS_CTRL0, 8'ha0);
      wr(ats_pkg::OFS_CTRL0, 8'h20);
      lat(n);
      check(n, 40);
      check(off, 1'b1);
   endtask
   task automatic finish_test();
      if (errors == 0 && checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   initial
   begin
      #800000;
      errors++;
      finish_test();
   end
   initial
   begin
      repeat (4) @(posedge clock);
      rst <= 1'b0;
      t_reset();
      t_conv();
      t_bound();
      t_pwm();
      finish_test();
   end
endmodule
